/* File: pkg/eem_consts.vh */
// constants shared by the endpoint event manager design files
// What this block does
// (R01) one bit per event, index equals number
// (R02) event bus assertion sets pending flag
// (R03) pending flags readable, write of ones clears
// (R04) repeat while pending sets repeat flag
// (R05) enable bit gates each event to reporting
// (R06) reported flags are pending and enable
// (R07) inject register ones act as events
// (R08) reported event raises management interrupt
// (R09) doorbell info low five bits event number
// (R10) doorbells cannot be disabled
// (R11) software keeps upper doorbell info reserved
// (R12) no port-write packets are generated
// (R13) events 0-3: phy, ltl, rx, tx
// (R14) 4-15 reserved, 16-31 user events
// (R15) logical ports drive their own event lines
// (R16) soft packet receive and transmit raise events
// (R17) maintenance requests become register cycles
// (R18) maintenance reads answered with register data
// (R19) arbitrate local and maintenance access, decode
// (R20) transmit finish with enable raises event
// (R21) interrupt held while any reported bit
// (R22) one doorbell per new reported bit, queued
// (R23) clearing pending also clears repeat flag
`ifndef EEM_CONSTS_VH
`define EEM_CONSTS_VH

// register byte offsets
`define EEM_OFS_PENDING   8'h00
`define EEM_OFS_REPEAT    8'h04
`define EEM_OFS_ENABLE    8'h08
`define EEM_OFS_REPORTED  8'h0c
`define EEM_OFS_INJECT    8'h10
`define EEM_OFS_SPTX_CTRL 8'h14
`define EEM_OFS_SPTX_STAT 8'h18
`define EEM_OFS_SPTX_DATA 8'h1c

// reset values
`define EEM_RST_ENABLE    32'h0000_0000
`define EEM_RST_INJECT    32'h0000_0000

// event numbers
`define EEM_EVT_PHY       0
`define EEM_EVT_LTL       1
`define EEM_EVT_SPRX      2
`define EEM_EVT_SPTX      3
`define EEM_EVT_USER_LO   16

// soft packet transmit control fields
`define EEM_TXC_CNT_MSB   15
`define EEM_TXC_EVT_EN    16
`define EEM_TX_WORD_OCT   16'h0004

// doorbell information field
`define EEM_DB_NUM_W      5
`define EEM_DB_INFO_HI    11'h000

`endif

/* File: verilog/eem_event_slice.v */
// one event slice: pending, repeat and reported flag for a single event
`default_nettype none

module eem_event_slice (
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // event and control
  input  wire evt,
  input  wire clr,
  input  wire en,
  // flags
  output reg  pending,
  output reg  repeated,
  output wire reported
);

  // set wins over a clear in the same cycle, so no event is lost
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pending  <= 1'b0;
      repeated <= 1'b0;
    end else begin
      pending  <= evt | (pending & ~clr); // (R02) (R03)
      if (evt && pending)
        repeated <= 1'b1; // (R04)
      else if (clr)
        repeated <= 1'b0; // (R23)
    end
  end

  assign reported = pending & en; // (R05) (R06)

endmodule

`default_nettype wire

/* File: verilog/eem_top.v */
// endpoint event manager: event unit, register arbiter, soft packet transmit counter
`include "eem_consts.vh"
`default_nettype none

module eem_top (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // local processor management port
  input  wire        lpm_req,
  input  wire        lpm_we,
  input  wire [7:0]  lpm_addr,
  input  wire [31:0] lpm_wdata,
  output reg         lpm_ack,
  output reg  [31:0] lpm_rdata,
  output reg         lpm_irq,
  // decoded maintenance requests
  input  wire        mnt_req,
  input  wire        mnt_we,
  input  wire [7:0]  mnt_addr,
  input  wire [31:0] mnt_wdata,
  input  wire [7:0]  mnt_tid,
  output reg         mnt_ack,
  // maintenance read responses
  output reg         mnt_rsp_valid,
  output reg  [7:0]  mnt_rsp_tid,
  output reg  [31:0] mnt_rsp_data,
  input  wire        mnt_rsp_ready,
  // event sources
  input  wire        phy_err_evt,
  input  wire        ltl_err_evt,
  input  wire        sp_rx_evt,
  input  wire [15:0] user_evt,
  // soft packet transmit words
  output reg         sp_tx_valid,
  output reg  [31:0] sp_tx_word,
  // doorbell to link
  output reg         db_valid,
  output reg  [15:0] db_info,
  input  wire        db_ready
);

  // soft packet transmit states
  localparam [1:0] TX_IDLE   = 2'b00;
  localparam [1:0] TX_ARMED  = 2'b01;
  localparam [1:0] TX_ACTIVE = 2'b10;

  // ------------------------------------------------------------------
  // arbitration between the two register masters
  // ------------------------------------------------------------------

  reg         last_mnt;
  wire        lpm_go;
  wire        mnt_go;
  wire        sel_mnt;
  wire        sel_lpm;
  wire        acc_go;
  wire        acc_we;
  wire [7:0]  acc_addr;
  wire [31:0] acc_wdata;

  // a master is not taken again while its ack is high: it drops req after
  // seeing the ack, so this avoids a double access
  assign lpm_go = lpm_req & ~lpm_ack;
  // a maintenance read waits until the previous response has left
  assign mnt_go = mnt_req & ~mnt_ack & ~mnt_rsp_valid; // (R17)

  // alternate when both wait, so neither master can starve the other
  assign sel_mnt = mnt_go & (~lpm_go | ~last_mnt); // (R19)
  assign sel_lpm = lpm_go & ~sel_mnt; // (R19)

  assign acc_go    = sel_mnt | sel_lpm;
  assign acc_we    = sel_mnt ? mnt_we    : lpm_we;
  assign acc_addr  = sel_mnt ? mnt_addr  : lpm_addr;
  assign acc_wdata = sel_mnt ? mnt_wdata : lpm_wdata;

  // block level address decode
  wire wr_pending;
  wire wr_enable;
  wire wr_inject;
  wire wr_txc;
  wire wr_txd;

  assign wr_pending = acc_go & acc_we & (acc_addr == `EEM_OFS_PENDING); // (R19)
  assign wr_enable  = acc_go & acc_we & (acc_addr == `EEM_OFS_ENABLE);
  assign wr_inject  = acc_go & acc_we & (acc_addr == `EEM_OFS_INJECT);
  assign wr_txc     = acc_go & acc_we & (acc_addr == `EEM_OFS_SPTX_CTRL);
  assign wr_txd     = acc_go & acc_we & (acc_addr == `EEM_OFS_SPTX_DATA);

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------

  reg  [31:0] ev_enable;
  reg  [31:0] ev_inject;
  reg  [31:0] inject_pulse;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ev_enable    <= `EEM_RST_ENABLE;
      ev_inject    <= `EEM_RST_INJECT;
      inject_pulse <= 32'h0000_0000;
    end else begin
      if (wr_enable)
        ev_enable <= acc_wdata;
      if (wr_inject)
        ev_inject <= acc_wdata;
      // a write injects once; the stored value is only for readback
      inject_pulse <= wr_inject ? acc_wdata : 32'h0000_0000; // (R07)
    end
  end

  // ------------------------------------------------------------------
  // soft packet transmit counter
  // ------------------------------------------------------------------

  reg  [1:0]  tx_state;
  reg  [15:0] tx_remain;
  reg         tx_evt_en;
  reg         sp_tx_evt;
  wire [15:0] tx_next_remain;

  // saturate so a short last word still ends the packet
  assign tx_next_remain = (tx_remain > `EEM_TX_WORD_OCT) ?
                          (tx_remain - `EEM_TX_WORD_OCT) : 16'h0000;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_state    <= TX_IDLE;
      tx_remain   <= 16'h0000;
      tx_evt_en   <= 1'b0;
      sp_tx_evt   <= 1'b0;
      sp_tx_valid <= 1'b0;
      sp_tx_word  <= 32'h0000_0000;
    end else begin
      sp_tx_evt   <= 1'b0;
      sp_tx_valid <= 1'b0;
      case (tx_state)
        TX_IDLE: begin
          if (wr_txc) begin
            tx_remain <= acc_wdata[`EEM_TXC_CNT_MSB:0];
            tx_evt_en <= acc_wdata[`EEM_TXC_EVT_EN];
            tx_state  <= TX_ARMED;
          end
        end
        TX_ARMED: begin
          if (wr_txd) begin
            sp_tx_valid <= 1'b1;
            sp_tx_word  <= acc_wdata;
            tx_remain   <= tx_next_remain;
            tx_state    <= TX_ACTIVE;
          end
        end
        TX_ACTIVE: begin
          if (tx_remain == 16'h0000) begin
            tx_state  <= TX_IDLE;
            sp_tx_evt <= tx_evt_en; // (R20) (R16)
          end else if (wr_txd) begin
            sp_tx_valid <= 1'b1;
            sp_tx_word  <= acc_wdata;
            tx_remain   <= tx_next_remain;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // event slices
  // ------------------------------------------------------------------

  wire [31:0] evt_bus;
  wire [31:0] ev_clear;
  wire [31:0] ev_pending;
  wire [31:0] ev_repeat;
  wire [31:0] ev_reported;

  // reserved numbers see no source but can still be injected
  assign evt_bus = {user_evt, 12'h000, sp_tx_evt, sp_rx_evt,
                    ltl_err_evt, phy_err_evt} | inject_pulse; // (R13) (R14) (R16) (R07)

  assign ev_clear = wr_pending ? acc_wdata : 32'h0000_0000; // (R03)

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : slice
      eem_event_slice u_slice ( // (R01)
        .sys_clk  (sys_clk),
        .rst      (rst),
        .evt      (evt_bus[g]),
        .clr      (ev_clear[g]),
        .en       (ev_enable[g]),
        .pending  (ev_pending[g]),
        .repeated (ev_repeat[g]),
        .reported (ev_reported[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // read mux and answers
  // ------------------------------------------------------------------

  reg [31:0] rd_mux;

  always @* begin
    case (acc_addr)
      `EEM_OFS_PENDING:   rd_mux = ev_pending;
      `EEM_OFS_REPEAT:    rd_mux = ev_repeat;
      `EEM_OFS_ENABLE:    rd_mux = ev_enable;
      `EEM_OFS_REPORTED:  rd_mux = ev_reported;
      `EEM_OFS_INJECT:    rd_mux = ev_inject;
      `EEM_OFS_SPTX_CTRL: rd_mux = {15'h0000, tx_evt_en, 16'h0000};
      `EEM_OFS_SPTX_STAT: rd_mux = {14'h0000, tx_state, tx_remain};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_mnt      <= 1'b0;
      lpm_ack       <= 1'b0;
      lpm_rdata     <= 32'h0000_0000;
      mnt_ack       <= 1'b0;
      mnt_rsp_valid <= 1'b0;
      mnt_rsp_tid   <= 8'h00;
      mnt_rsp_data  <= 32'h0000_0000;
    end else begin
      lpm_ack <= sel_lpm;
      mnt_ack <= sel_mnt;
      if (acc_go)
        last_mnt <= sel_mnt;
      if (sel_lpm)
        lpm_rdata <= acc_we ? 32'h0000_0000 : rd_mux;
      if (sel_mnt && !mnt_we) begin
        mnt_rsp_valid <= 1'b1; // (R18)
        mnt_rsp_tid   <= mnt_tid;
        mnt_rsp_data  <= rd_mux; // (R18)
      end else if (mnt_rsp_ready) begin
        mnt_rsp_valid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // reporting: interrupt and doorbell
  // ------------------------------------------------------------------

  // port-write reporting is deliberately absent (R12)
  reg  [31:0] rep_q;
  reg  [31:0] db_pend;
  reg  [4:0]  db_num;
  reg  [4:0]  db_pick;
  reg  [31:0] db_done;
  integer     i;

  always @* begin
    db_pick = 5'h00;
    for (i = 31; i >= 0; i = i - 1) begin
      if (db_pend[i])
        db_pick = i[4:0];
    end
  end

  always @* begin
    db_done = 32'h0000_0000;
    if (db_valid && db_ready)
      db_done[db_num] = 1'b1;
  end

  // doorbells have no off switch by design (R10)
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rep_q    <= 32'h0000_0000;
      db_pend  <= 32'h0000_0000;
      db_num   <= 5'h00;
      db_valid <= 1'b0;
      db_info  <= 16'h0000;
      lpm_irq  <= 1'b0;
    end else begin
      lpm_irq <= |ev_reported; // (R08) (R21)
      rep_q   <= ev_reported;
      // a bit rising again while its doorbell leaves is kept queued
      db_pend <= (db_pend & ~db_done) | (ev_reported & ~rep_q); // (R22)
      if (db_valid) begin
        if (db_ready)
          db_valid <= 1'b0; // (R22)
      end else if (|db_pend) begin
        db_valid <= 1'b1;
        db_num   <= db_pick;
        db_info  <= {`EEM_DB_INFO_HI, db_pick}; // (R09) (R11)
      end
    end
  end

endmodule

`default_nettype wire

/* File: dv/eem_asserts.sv */
// port checks for the endpoint event manager
`default_nettype none
module eem_asserts (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // local port
  input wire logic        lpm_req,
  input wire logic        lpm_ack,
  // maintenance
  input wire logic        mnt_req,
  input wire logic        mnt_we,
  input wire logic [7:0]  mnt_tid,
  input wire logic        mnt_ack,
  input wire logic        mnt_rsp_valid,
  input wire logic [7:0]  mnt_rsp_tid,
  input wire logic [31:0] mnt_rsp_data,
  input wire logic        mnt_rsp_ready,
  // doorbell
  input wire logic        db_valid,
  input wire logic [15:0] db_info,
  input wire logic        db_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_lpm_ack_pulse: assert property (lpm_ack |=> !lpm_ack)
    else $error("local ack too long");
  a_lpm_prompt: assert property (lpm_req && !lpm_ack && !mnt_req |=> lpm_ack)
    else $error("local access not answered next cycle");
  a_lpm_bounded: assert property (lpm_req && !lpm_ack |-> ##[1:2] lpm_ack)
    else $error("local access starved");
  a_mnt_bounded: assert property (mnt_req && !mnt_ack && !mnt_rsp_valid |-> ##[1:2] mnt_ack)
    else $error("maintenance access starved");
  a_mnt_ack_pulse: assert property (mnt_ack |=> !mnt_ack)
    else $error("maintenance ack too long");
  a_rsp_tid_echo: assert property (mnt_ack && !$past(mnt_we) |->
      mnt_rsp_valid && mnt_rsp_tid == $past(mnt_tid))
    else $error("read response missing or tid wrong");
  a_write_no_rsp: assert property (mnt_ack && $past(mnt_we) |-> !mnt_rsp_valid)
    else $error("response after maintenance write");
  a_rsp_hold: assert property (mnt_rsp_valid && !mnt_rsp_ready |=>
      mnt_rsp_valid && $stable(mnt_rsp_data) && $stable(mnt_rsp_tid))
    else $error("read response dropped or changed");
  a_db_hold: assert property (db_valid && !db_ready |=> db_valid && $stable(db_info))
    else $error("doorbell dropped or changed");
  a_db_high_zero: assert property (db_valid |-> db_info[15:5] == 11'h000)
    else $error("doorbell upper info not zero");
  a_db_bubble: assert property (db_valid && db_ready |=> !db_valid)
    else $error("doorbells back to back");
endmodule
bind eem_top eem_asserts u_chk (.sys_clk, .rst, .lpm_req, .lpm_ack, .mnt_req, .mnt_we,
  .mnt_tid, .mnt_ack, .mnt_rsp_valid, .mnt_rsp_tid, .mnt_rsp_data, .mnt_rsp_ready,
  .db_valid, .db_info, .db_ready);
`default_nettype wire

/* File: dv/eem_partner.sv */
// far side model: doorbell sink and read response sink
`default_nettype none
module eem_partner (
  // clock, reset and pacing
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  // doorbells
  input  wire logic        db_valid,
  input  wire logic [15:0] db_info,
  output var  logic        db_ready,
  output var  logic [31:0] db_hist,
  // read responses
  input  wire logic        mnt_rsp_valid,
  input  wire logic [7:0]  mnt_rsp_tid,
  input  wire logic [31:0] mnt_rsp_data,
  output var  logic        mnt_rsp_ready,
  output var  logic [7:0]  rsp_tid,
  output var  logic [31:0] rsp_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] pace;
  // a congested link takes one transfer in four
  assign db_ready = !slow || pace == 2'h3;
  assign mnt_rsp_ready = db_ready;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pace <= 2'h0;
      db_hist <= 32'h0;
      rsp_tid <= 8'h00;
      rsp_data <= 32'h0;
    end else begin
      pace <= pace + 2'h1;
      // only the low info bits matter, they carry event numbers
      if (db_valid && db_ready) db_hist <= {db_hist[23:0], db_info[7:0]};
      if (mnt_rsp_valid && mnt_rsp_ready) begin
        rsp_tid <= mnt_rsp_tid;
        rsp_data <= mnt_rsp_data;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the endpoint event manager
`include "eem_consts.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        slow = 1'b0;
  logic        lpm_req = 1'b0, lpm_we = 1'b0, mnt_req = 1'b0, mnt_we = 1'b0;
  logic [7:0]  lpm_addr = 8'h00, mnt_addr = 8'h00, mnt_tid = 8'h00;
  logic [31:0] lpm_wdata = 32'h0, mnt_wdata = 32'h0, ev = 32'h0, rd;
  wire         lpm_ack, lpm_irq, mnt_ack, mnt_rsp_valid, mnt_rsp_ready;
  wire         sp_tx_valid, db_valid, db_ready;
  wire  [7:0]  mnt_rsp_tid, rsp_tid;
  wire  [15:0] db_info;
  wire  [31:0] lpm_rdata, mnt_rsp_data, sp_tx_word, db_hist, rsp_data;
  int          failures = 0, samples_checked = 0, tx_words = 0;
  eem_top DUT (.sys_clk, .rst, .lpm_req, .lpm_we, .lpm_addr, .lpm_wdata, .lpm_ack,
    .lpm_rdata, .lpm_irq, .mnt_req, .mnt_we, .mnt_addr, .mnt_wdata, .mnt_tid, .mnt_ack,
    .mnt_rsp_valid, .mnt_rsp_tid, .mnt_rsp_data, .mnt_rsp_ready, .phy_err_evt(ev[0]),
    .ltl_err_evt(ev[1]), .sp_rx_evt(ev[2]), .user_evt(ev[31:16]), .sp_tx_valid,
    .sp_tx_word, .db_valid, .db_info, .db_ready);
  eem_partner far_end (.sys_clk, .rst, .slow, .db_valid, .db_info, .db_ready, .db_hist,
    .mnt_rsp_valid, .mnt_rsp_tid, .mnt_rsp_data, .mnt_rsp_ready, .rsp_tid, .rsp_data);
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sp_tx_valid === 1'b1) tx_words++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lpm(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) #1;
    {lpm_req, lpm_we, lpm_addr, lpm_wdata} = {1'b1, we, a, d};
    repeat (20) begin
      @(posedge sys_clk);
      if (lpm_ack === 1'b1) break;
    end
    rd = lpm_rdata;
    #1 lpm_req = 1'b0;
  endtask
  task automatic mnt(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [7:0] t);
    @(posedge sys_clk) #1;
    {mnt_req, mnt_we, mnt_addr, mnt_wdata, mnt_tid} = {1'b1, we, a, d, t};
    repeat (20) begin
      @(posedge sys_clk);
      if (mnt_ack === 1'b1) break;
    end
    #1 mnt_req = 1'b0;
  endtask
  // user event lines stand in for the logical port functions
  task automatic pulse(input logic [31:0] m);
    @(posedge sys_clk) #1 ev = m;
    @(posedge sys_clk) #1 ev = 32'h0;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    lpm(0, `EEM_OFS_ENABLE, 0); chk(rd, `EEM_RST_ENABLE);
    lpm(0, `EEM_OFS_INJECT, 0); chk(rd, `EEM_RST_INJECT);
    lpm(0, 8'hfc, 0); chk(rd, 32'h0);
    $display("test reset done");
    pulse(32'hffff_0007);
    pulse(32'h0000_0001);
    lpm(0, `EEM_OFS_PENDING, 0); chk(rd, 32'hffff_0007);
    lpm(0, `EEM_OFS_REPEAT, 0); chk(rd, 32'h1);
    lpm(0, `EEM_OFS_REPORTED, 0); chk(rd, 32'h0);
    chk(lpm_irq, 32'h0);
    slow = 1'b1;
    lpm(1, `EEM_OFS_ENABLE, 32'h0001_0001);
    lpm(0, `EEM_OFS_REPORTED, 0); chk(rd, 32'h0001_0001);
    chk(lpm_irq, 32'h1);
    for (int i = 0; i < 40 && db_hist !== 32'h10; i++) @(posedge sys_clk);
    chk(db_hist, 32'h10);
    lpm(1, `EEM_OFS_PENDING, 32'h1);
    lpm(0, `EEM_OFS_PENDING, 0); chk(rd, 32'hffff_0006);
    lpm(0, `EEM_OFS_REPEAT, 0); chk(rd, 32'h0);
    lpm(1, `EEM_OFS_PENDING, 32'hffff_ffff);
    lpm(0, `EEM_OFS_REPORTED, 0); chk(rd, 32'h0);
    chk(lpm_irq, 32'h0);
    chk(db_hist, 32'h10);
    $display("test logging and reporting done");
    lpm(1, `EEM_OFS_INJECT, 32'h8);
    lpm(0, `EEM_OFS_PENDING, 0); chk(rd, 32'h8);
    lpm(1, `EEM_OFS_PENDING, 32'h8);
    lpm(1, `EEM_OFS_SPTX_CTRL, 32'h0001_0008);
    lpm(1, `EEM_OFS_SPTX_DATA, 32'hcafe_0001);
    lpm(1, `EEM_OFS_SPTX_DATA, 32'hcafe_0002);
    lpm(0, `EEM_OFS_SPTX_STAT, 0); chk(rd, 32'h0);
    chk(tx_words, 32'h2);
    chk(sp_tx_word, 32'hcafe_0002);
    lpm(0, `EEM_OFS_PENDING, 0); chk(rd, 32'h8);
    $display("test transmit events done");
    mnt(1, `EEM_OFS_ENABLE, 32'h8, 8'h01);
    fork
      mnt(0, `EEM_OFS_ENABLE, 0, 8'h5a);
      lpm(0, `EEM_OFS_ENABLE, 0);
    join
    chk(rd, 32'h8);
    for (int i = 0; i < 40 && rsp_tid !== 8'h5a; i++) @(posedge sys_clk);
    chk(rsp_tid, 32'h5a);
    chk(rsp_data, 32'h8);
    for (int i = 0; i < 40 && db_hist !== 32'h1003; i++) @(posedge sys_clk);
    chk(db_hist, 32'h1003);
    $display("test maintenance done");
    chk(lpm_irq, 32'h1);
    lpm(1, `EEM_OFS_PENDING, 32'hffff_ffff);
    // event enable off and a count that is not a word multiple
    lpm(1, `EEM_OFS_SPTX_CTRL, 32'h0000_0005);
    lpm(1, `EEM_OFS_SPTX_DATA, 32'h0000_0001);
    lpm(1, `EEM_OFS_SPTX_DATA, 32'h0000_0002);
    lpm(0, `EEM_OFS_SPTX_STAT, 0); chk(rd, 32'h0);
    chk(tx_words, 32'h4);
    lpm(0, `EEM_OFS_PENDING, 0); chk(rd, 32'h0);
    chk(lpm_irq, 32'h0);
    $display("test silent transmit done");
    print_verdict();
  end
endmodule
`default_nettype wire
